// [verilog/ccu_defs.svh]
// register map, field positions, mode codes and reset values of the unit
`ifndef CCU_DEFS_SVH
`define CCU_DEFS_SVH

// register map: address bit 4 picks the unit, bits 3:2 the register
`define CCU_UNIT_BIT       4
`define CCU_OFF_CTRL       4'h0
`define CCU_OFF_VALUE_LOW  4'h4
`define CCU_OFF_VALUE_HIGH 4'h8
`define CCU_OFF_FLAG       4'hC
`define CCU_ENH_IDX        0
`define CCU_PLAIN_IDX      1

// reset values
`define CCU_CTRL_RESET     8'h00
`define CCU_VALUE_RESET    16'h0000
`define CCU_OE_N_RESET     4'hF

// control field positions and masks
`define CCU_FLAG_BIT       0
`define CCU_PLAIN_MASK     8'h3F

// mode codes
`define CCU_MODE_OFF       4'h0
`define CCU_MODE_TOGGLE    4'h2
`define CCU_MODE_FALL      4'h4
`define CCU_MODE_RISE      4'h5
`define CCU_MODE_RISE4     4'h6
`define CCU_MODE_RISE16    4'h7
`define CCU_MODE_SET       4'h8
`define CCU_MODE_CLEAR     4'h9
`define CCU_MODE_SOFT      4'hA
`define CCU_MODE_SPECIAL   4'hB

// capture prescaler terminal counts
`define CCU_PRESC_4_LAST   2'h3
`define CCU_PRESC_16_LAST  4'hF

// output configuration codes
`define CCU_CFG_SINGLE     2'h0
`define CCU_CFG_FULL_FWD   2'h1
`define CCU_CFG_HALF       2'h2
`define CCU_CFG_FULL_REV   2'h3

// bus responses
`define CCU_RESP_OKAY      2'h0
`define CCU_RESP_SLVERR    2'h2

`endif

// [verilog/ccu_pkg.sv]
// types shared by the capture/compare unit
`default_nettype none
package ccu_pkg;

    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } ccu_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } ccu_axi_rsp_t;

    typedef enum logic [3:0] {
        CCU_OFF, CCU_CAPTURE, CCU_CMP_SET, CCU_CMP_CLR, CCU_CMP_TOG,
        CCU_CMP_SOFT, CCU_CMP_SPECIAL, CCU_WAVE, CCU_RESERVED
    } ccu_kind_t;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [15:0] value;
        logic        flag;
        logic        out_latch;
        logic [3:0]  presc;
        logic [2:0]  pin_sync;
        logic        pin_level;
        logic        match_q;
        logic        rst_pending;
        logic [3:0]  pin_out;
        logic [3:0]  pin_oe_n;
    } ccu_unit_t;

    typedef struct packed {
        ccu_unit_t [1:0] unit;
        logic            awpend;
        logic [7:0]      awaddr;
        logic            wpend;
        logic [31:0]     wdata;
        logic [3:0]      wstrb;
        ccu_axi_rsp_t    rsp;
        logic            tmr_rst;
        logic            adc_start;
    } ccu_state_t;

endpackage : ccu_pkg
`default_nettype wire

// [verilog/ccu_top.sv]
// capture/compare unit pair (enhanced and plain) with an AXI4-Lite slave
//
// Contract
// - Mode 0000 turns a unit off, clearing prescaler, output and match.
// - Capture on falling, rising, every 4th or every 16th rising pin edge.
// - Each capture copies the whole 16-bit timer count into the value pair.
// - A capture sets the unit flag; only a software write clears it.
// - A new capture overwrites the stored value with no overrun sign.
// - Prescaler counter clears when off, outside capture modes, and on reset.
// - Prescaler setting changes keep the counter; a false capture may follow.
// - Edges are seen on the pin level even while the pin is driven.
// - Compare modes keep comparing the 16-bit value pair with the timer.
// - Match drives output high in 1000, low in 1001; both set the flag.
// - Mode 1010 match sets only the flag; pin untouched.
// - Mode 1011 match sets flag, resets timer, starts conversion; no pin.
// - Enhanced unit toggles output on match in 0010; reserved in plain.
// - Codes 0001 and 0011 select no function in either unit.
// - Codes 11xx select waveform; in the enhanced unit mode bits 1 and 0 invert A/C and B/D, the plain unit drives the wave uninverted.
// - Control bits 5-4 hold duty low bits, ignored in capture and compare.
// - Output config bits 7-6 act only in waveform mode; else A is the pin.
// - Trigger fires on match; timer reset waits for the next timer tick.
// - Clearing the control register forces the compare output latch low.
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defs.svh"

module ccu_top (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    // register bus
    input  wire ccu_pkg::ccu_axi_req_t axi_req,
    output var  ccu_pkg::ccu_axi_rsp_t axi_rsp,
    // timer one
    input  wire logic [15:0]           timer_one_count,
    input  wire logic                  timer_one_tick,
    output logic                       timer_one_reset,
    output logic                       adc_start,
    // pins: index 0 enhanced (out_a), index 1 plain
    input  wire logic [1:0]            pin_in,
    input  wire logic [1:0]            pwm_wave,
    output logic [3:0]                 enh_pin_out,
    output logic [3:0]                 enh_pin_oe_n,
    output logic                       plain_pin_out,
    output logic                       plain_pin_oe_n,
    // flags toward the interrupt flag register
    output logic [1:0]                 cc_irq_flag
);

    ccu_pkg::ccu_state_t s_q;
    ccu_pkg::ccu_state_t s_d;

    // classify a mode code for one unit
    function automatic ccu_pkg::ccu_kind_t mode_kind(input logic [3:0] mode,
                                                      input logic       enh);
        ccu_pkg::ccu_kind_t k;
        k = ccu_pkg::CCU_RESERVED;
        if (mode == `CCU_MODE_OFF) begin
            k = ccu_pkg::CCU_OFF;
        end else if (mode[3:2] == 2'b01) begin
            k = ccu_pkg::CCU_CAPTURE;
        end else if (mode[3:2] == 2'b11) begin
            k = ccu_pkg::CCU_WAVE;
        end else if (mode == `CCU_MODE_SET) begin
            k = ccu_pkg::CCU_CMP_SET;
        end else if (mode == `CCU_MODE_CLEAR) begin
            k = ccu_pkg::CCU_CMP_CLR;
        end else if (mode == `CCU_MODE_SOFT) begin
            k = ccu_pkg::CCU_CMP_SOFT;
        end else if (mode == `CCU_MODE_SPECIAL) begin
            k = ccu_pkg::CCU_CMP_SPECIAL;
        end else if (mode == `CCU_MODE_TOGGLE && enh) begin
            k = ccu_pkg::CCU_CMP_TOG;
        end
        return k;
    endfunction : mode_kind

    function automatic logic is_compare(input ccu_pkg::ccu_kind_t k);
        return k inside {ccu_pkg::CCU_CMP_SET, ccu_pkg::CCU_CMP_CLR,
                         ccu_pkg::CCU_CMP_TOG, ccu_pkg::CCU_CMP_SOFT,
                         ccu_pkg::CCU_CMP_SPECIAL};
    endfunction : is_compare

    // the map holds two units of four registers each
    function automatic logic addr_hit(input logic [7:0] addr);
        return addr[7:5] == 3'h0;
    endfunction : addr_hit

    logic                wr_fire;
    logic                wr_unit;
    logic [3:0]          wr_off;
    logic                enh;
    logic                pin_edge;
    logic                rise_edge;
    logic                fall_edge;
    logic                cap;
    logic                match;
    logic                match_rise;
    logic                wave;
    logic [3:0]          raw;
    logic                rd_unit;
    ccu_pkg::ccu_kind_t  kind;
    ccu_pkg::ccu_kind_t  kind_n;
    ccu_pkg::ccu_unit_t  u;
    ccu_pkg::ccu_unit_t  n;

    always_comb begin
        s_d        = s_q;
        wr_fire    = 1'b0;
        wr_unit    = 1'b0;
        wr_off     = 4'h0;
        enh        = 1'b0;
        pin_edge   = 1'b0;
        rise_edge  = 1'b0;
        fall_edge  = 1'b0;
        cap        = 1'b0;
        match      = 1'b0;
        match_rise = 1'b0;
        wave       = 1'b0;
        raw        = 4'h0;
        rd_unit    = 1'b0;
        kind       = ccu_pkg::CCU_OFF;
        kind_n     = ccu_pkg::CCU_OFF;
        u          = s_q.unit[0];
        n          = s_q.unit[0];
        s_d.tmr_rst   = 1'b0;
        s_d.adc_start = 1'b0;

        // write address and data are taken in either order
        if (axi_req.awvalid && s_q.rsp.awready) begin
            s_d.awpend = 1'b1;
            s_d.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s_q.rsp.wready) begin
            s_d.wpend = 1'b1;
            s_d.wdata = axi_req.wdata;
            s_d.wstrb = axi_req.wstrb;
        end
        if (s_q.rsp.bvalid && axi_req.bready) begin
            s_d.rsp.bvalid = 1'b0;
        end
        if (s_q.awpend && s_q.wpend && !s_q.rsp.bvalid) begin
            wr_fire        = addr_hit(s_q.awaddr) && s_q.wstrb[0];
            wr_unit        = s_q.awaddr[`CCU_UNIT_BIT];
            wr_off         = {s_q.awaddr[3:2], 2'b00};
            s_d.awpend     = 1'b0;
            s_d.wpend      = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp  = addr_hit(s_q.awaddr) ? `CCU_RESP_OKAY
                                                   : `CCU_RESP_SLVERR;
        end

        for (int i = 0; i < 2; i++) begin
            u   = s_q.unit[i];
            n   = u;
            enh = (i == `CCU_ENH_IDX);
            kind = mode_kind(u.ctrl[3:0], enh);

            // three-flop synchronizer; change counts once 2nd and 3rd agree
            n.pin_sync = {u.pin_sync[1:0], pin_in[i]};
            pin_edge   = (u.pin_sync[1] == u.pin_sync[2]) &&
                         (u.pin_sync[2] != u.pin_level);
            rise_edge  = pin_edge && u.pin_sync[2];
            fall_edge  = pin_edge && !u.pin_sync[2];
            if (pin_edge) begin
                n.pin_level = u.pin_sync[2];
            end

            // capture event qualification
            cap = 1'b0;
            if (kind == ccu_pkg::CCU_CAPTURE) begin
                unique case (u.ctrl[1:0])
                    2'b00: cap = fall_edge;
                    2'b01: cap = rise_edge;
                    2'b10: begin
                        if (rise_edge) begin
                            n.presc = u.presc + 4'h1;
                            if (u.presc[1:0] == `CCU_PRESC_4_LAST) begin
                                cap     = 1'b1;
                                n.presc = 4'h0;
                            end
                        end
                    end
                    2'b11: begin
                        if (rise_edge) begin
                            n.presc = u.presc + 4'h1;
                            if (u.presc == `CCU_PRESC_16_LAST) begin
                                cap     = 1'b1;
                                n.presc = 4'h0;
                            end
                        end
                    end
                endcase
            end
            if (cap) begin
                n.value = timer_one_count;
                n.flag  = 1'b1;
            end

            // compare against the timer, acting once per new match
            match      = (timer_one_count == u.value) && is_compare(kind);
            match_rise = match && !u.match_q;
            n.match_q  = match;
            if (match_rise) begin
                n.flag = 1'b1;
                unique case (kind)
                    ccu_pkg::CCU_CMP_SET:     n.out_latch = 1'b1;
                    ccu_pkg::CCU_CMP_CLR:     n.out_latch = 1'b0;
                    ccu_pkg::CCU_CMP_TOG:     n.out_latch = !u.out_latch;
                    ccu_pkg::CCU_CMP_SPECIAL: begin
                        s_d.adc_start = 1'b1;
                        n.rst_pending = 1'b1;
                    end
                    default: ;
                endcase
            end
            // timer reset lands on the next tick, dropped if the match goes
            if (u.rst_pending) begin
                if (!match) begin
                    n.rst_pending = 1'b0;
                end else if (timer_one_tick) begin
                    s_d.tmr_rst   = 1'b1;
                    n.rst_pending = 1'b0;
                end
            end

            // software writes; hardware capture and flag set win
            if (wr_fire && wr_unit == i[0]) begin
                unique case (wr_off)
                    `CCU_OFF_CTRL: begin
                        n.ctrl = enh ? s_q.wdata[7:0]
                                     : s_q.wdata[7:0] & `CCU_PLAIN_MASK;
                    end
                    `CCU_OFF_VALUE_LOW: begin
                        if (!cap) begin
                            n.value[7:0] = s_q.wdata[7:0];
                        end
                    end
                    `CCU_OFF_VALUE_HIGH: begin
                        if (!cap) begin
                            n.value[15:8] = s_q.wdata[7:0];
                        end
                    end
                    `CCU_OFF_FLAG: begin
                        if (s_q.wdata[`CCU_FLAG_BIT] && !cap &&
                            !match_rise) begin
                            n.flag = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end

            kind_n = mode_kind(n.ctrl[3:0], enh);
            if (kind_n != ccu_pkg::CCU_CAPTURE) begin
                n.presc = 4'h0;
            end
            if (!is_compare(kind_n)) begin
                n.rst_pending = 1'b0;
                n.match_q     = 1'b0;
            end
            if (n.ctrl == `CCU_CTRL_RESET) begin
                n.out_latch   = 1'b0;
                n.presc       = 4'h0;
                n.rst_pending = 1'b0;
            end

            // pin drive; duty low bits are not used here
            wave       = pwm_wave[i];
            n.pin_out  = 4'h0;
            n.pin_oe_n = `CCU_OE_N_RESET;
            if (kind_n inside {ccu_pkg::CCU_CMP_SET, ccu_pkg::CCU_CMP_CLR,
                               ccu_pkg::CCU_CMP_TOG}) begin
                n.pin_out  = {3'b000, n.out_latch};
                n.pin_oe_n = 4'hE;
            end else if (kind_n == ccu_pkg::CCU_WAVE && !enh) begin
                n.pin_out  = {3'b000, wave};
                n.pin_oe_n = 4'hE;
            end else if (kind_n == ccu_pkg::CCU_WAVE) begin
                // raw is {d, c, b, a}
                unique case (n.ctrl[7:6])
                    `CCU_CFG_SINGLE: begin
                        raw        = {3'b000, wave};
                        n.pin_oe_n = 4'hE;
                    end
                    `CCU_CFG_FULL_FWD: begin
                        raw        = {wave, 1'b0, 1'b0, 1'b1};
                        n.pin_oe_n = 4'h0;
                    end
                    `CCU_CFG_HALF: begin
                        raw        = {1'b0, 1'b0, !wave, wave};
                        n.pin_oe_n = 4'hC;
                    end
                    `CCU_CFG_FULL_REV: begin
                        raw        = {1'b0, 1'b1, wave, 1'b0};
                        n.pin_oe_n = 4'h0;
                    end
                endcase
                n.pin_out = raw ^ {n.ctrl[0], n.ctrl[1],
                                   n.ctrl[0], n.ctrl[1]};
            end
            s_d.unit[i] = n;
        end

        // read channel
        if (s_q.rsp.rvalid && axi_req.rready) begin
            s_d.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && s_q.rsp.arready) begin
            rd_unit        = axi_req.araddr[`CCU_UNIT_BIT];
            u              = s_q.unit[rd_unit];
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rdata  = 32'h0000_0000;
            s_d.rsp.rresp  = `CCU_RESP_SLVERR;
            if (addr_hit(axi_req.araddr)) begin
                s_d.rsp.rresp = `CCU_RESP_OKAY;
                unique case ({axi_req.araddr[3:2], 2'b00})
                    `CCU_OFF_CTRL:       s_d.rsp.rdata[7:0] = u.ctrl;
                    `CCU_OFF_VALUE_LOW:  s_d.rsp.rdata[7:0] = u.value[7:0];
                    `CCU_OFF_VALUE_HIGH: s_d.rsp.rdata[7:0] = u.value[15:8];
                    `CCU_OFF_FLAG:       s_d.rsp.rdata[0]   = u.flag;
                    default: ;
                endcase
            end
        end

        s_d.rsp.awready = !s_d.awpend && !s_d.rsp.bvalid;
        s_d.rsp.wready  = !s_d.wpend && !s_d.rsp.bvalid;
        s_d.rsp.arready = !s_d.rsp.rvalid;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_q <= '0;
            for (int i = 0; i < 2; i++) begin
                s_q.unit[i].ctrl     <= `CCU_CTRL_RESET;
                s_q.unit[i].value    <= `CCU_VALUE_RESET;
                s_q.unit[i].presc    <= 4'h0;
                s_q.unit[i].pin_oe_n <= `CCU_OE_N_RESET;
            end
        end else begin
            s_q <= s_d;
        end
    end

    assign axi_rsp         = s_q.rsp;
    assign timer_one_reset = s_q.tmr_rst;
    assign adc_start       = s_q.adc_start;
    assign enh_pin_out     = s_q.unit[`CCU_ENH_IDX].pin_out;
    assign enh_pin_oe_n    = s_q.unit[`CCU_ENH_IDX].pin_oe_n;
    assign plain_pin_out   = s_q.unit[`CCU_PLAIN_IDX].pin_out[0];
    assign plain_pin_oe_n  = s_q.unit[`CCU_PLAIN_IDX].pin_oe_n[0];
    assign cc_irq_flag     = {s_q.unit[`CCU_PLAIN_IDX].flag,
                              s_q.unit[`CCU_ENH_IDX].flag};

endmodule : ccu_top
`default_nettype wire

// [tb/ccu_chk.sv]
// concurrent checks on the ports of the capture/compare unit pair
`timescale 1ns/1ps
`default_nettype none
module ccu_chk (
    // clock and reset
    input wire logic                  sys_clk,
    input wire logic                  reset,
    // register bus
    input wire ccu_pkg::ccu_axi_req_t axi_req,
    input wire ccu_pkg::ccu_axi_rsp_t axi_rsp,
    // timer and pins
    input wire logic                  timer_one_tick,
    input wire logic                  timer_one_reset,
    input wire logic                  adc_start,
    input wire logic [3:0]            enh_pin_oe_n,
    input wire logic [1:0]            cc_irq_flag
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    AST_RST_OUT: assert property ($past(reset) |->
        enh_pin_oe_n == 4'hF && cc_irq_flag == 2'h0)
        else $error("outputs not at reset level");
    AST_TRST_TICK: assert property (timer_one_reset |->
        $past(timer_one_tick)) else $error("timer reset off tick");
    AST_ADC_ONCE: assert property (adc_start |=> !adc_start)
        else $error("trigger longer than one cycle");
    AST_FLAG_SW0: assert property ($fell(cc_irq_flag[0]) |->
        $past(axi_rsp.awready) == 1'b0 || $past(reset))
        else $error("flag cleared without a write");
    AST_FLAG_SW1: assert property ($fell(cc_irq_flag[1]) |->
        $past(axi_rsp.awready) == 1'b0 || $past(reset))
        else $error("plain flag cleared without a write");
    AST_B_BUSY: assert property (axi_rsp.bvalid |->
        !axi_rsp.awready && !axi_rsp.wready)
        else $error("write channel open during response");
    AST_R_NEXT: assert property (axi_req.arvalid && axi_rsp.arready
        |=> axi_rsp.rvalid && !axi_rsp.arready)
        else $error("read answer late");
    AST_PLAIN_TOP: assert property (axi_req.arvalid
        && axi_rsp.arready && axi_req.araddr == 8'h10
        |=> axi_rsp.rdata[31:6] == 26'h0)
        else $error("plain control upper bits set");
    AST_REFUSE: assert property (axi_req.arvalid && axi_rsp.arready
        && axi_req.araddr[7:5] != 3'h0
        |=> axi_rsp.rresp == 2'h2 && axi_rsp.rdata == 32'h0)
        else $error("unmapped read not refused");
    cover property ($rose(cc_irq_flag[0]));
    cover property ($rose(cc_irq_flag[1]));
    cover property (timer_one_reset);
endmodule : ccu_chk
bind ccu_top ccu_chk i_chk (.sys_clk, .reset, .axi_req, .axi_rsp,
    .timer_one_tick, .timer_one_reset, .adc_start, .enh_pin_oe_n,
    .cc_irq_flag);
`default_nettype wire

// [tb/ccu_pin_model.sv]
// outside source on the two capture/compare pins
`timescale 1ns/1ps
`default_nettype none
module ccu_pin_model (
    // level the outside source wants
    input  wire logic [1:0] src_level,
    // unit drive
    input  wire logic       enh_out,
    input  wire logic       enh_oe_n,
    input  wire logic       plain_out,
    input  wire logic       plain_oe_n,
    // resolved pin levels
    output logic [1:0]      pin_level
);
    // a driven pin reads back what the unit drives
    assign pin_level[0] = enh_oe_n ? src_level[0] : enh_out;
    assign pin_level[1] = plain_oe_n ? src_level[1] : plain_out;
endmodule : ccu_pin_model
`default_nettype wire

// [tb/capture_compare_unit_tb.sv]
// self-checking bench for the capture/compare unit pair
`timescale 1ns/1ps
`default_nettype none
module capture_compare_unit_tb;
    logic                  sys_clk;
    logic                  reset;
    ccu_pkg::ccu_axi_req_t rq;
    ccu_pkg::ccu_axi_rsp_t rs;
    logic [15:0]           tcnt;
    logic                  tick;
    logic                  trst;
    logic                  adc;
    logic [1:0]            src;
    logic [1:0]            pins;
    logic [1:0]            pw;
    logic [3:0]            eo;
    logic [3:0]            eoe_n;
    logic                  po;
    logic                  poe_n;
    logic [1:0]            flg;
    logic [31:0]           d;
    logic [31:0]           d2;
    logic [15:0]           v;
    logic                  lat;
    logic [1:0]            br;
    int                    miscompares;
    int                    n_tests;
    int                    nadc;
    int                    seed;
    int                    k;
    int                    u;
    int                    m;
    int                    n;
    int                    mt[11] = '{8, 9, 2, 0, 2, 10, 11, 2, 1, 3, 8};
    ccu_top i_dut (.sys_clk(sys_clk), .reset(reset), .axi_req(rq),
        .axi_rsp(rs), .timer_one_count(tcnt), .timer_one_tick(tick),
        .timer_one_reset(trst), .adc_start(adc), .pin_in(pins),
        .pwm_wave(pw), .enh_pin_out(eo), .enh_pin_oe_n(eoe_n),
        .plain_pin_out(po), .plain_pin_oe_n(poe_n), .cc_irq_flag(flg));
    ccu_pin_model i_pin (.src_level(src), .enh_out(eo[0]),
        .enh_oe_n(eoe_n[0]), .plain_out(po), .plain_oe_n(poe_n),
        .pin_level(pins));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // timer one ticks every other cycle and is cleared on request
    always @(posedge sys_clk) begin
        tick <= ~tick;
        if (trst) tcnt <= 16'h0000;
        if (adc) nadc <= nadc + 1;
    end
    task automatic w(input int c);
        repeat (c) @(posedge sys_clk);
    endtask : w
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input int a, input int x);
        rq.awaddr <= 8'(a);
        rq.awvalid <= 1'b1;
        rq.wdata <= 32'(x);
        rq.wstrb <= 4'hF;
        rq.wvalid <= 1'b1;
        rq.bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (rs.awready) rq.awvalid <= 1'b0;
            if (rs.wready) rq.wvalid <= 1'b0;
        end while (!rs.bvalid);
        br = rs.bresp;
    endtask : wr
    task automatic rd(input int a, output logic [31:0] x);
        rq.araddr <= 8'(a);
        rq.arvalid <= 1'b1;
        rq.rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (rs.arready) rq.arvalid <= 1'b0;
        end while (!rs.rvalid);
        x = rs.rdata;
    endtask : rd
    task automatic pulse(input int p, input int c);
        repeat (c) begin
            src[p] <= 1'b1;
            w(6);
            src[p] <= 1'b0;
            w(6);
        end
    endtask : pulse
    task automatic value(input int b, input logic [15:0] e);
        rd(b + 4, d);
        rd(b + 8, d2);
        chk({d2[7:0], d[7:0]}, 32'(e));
    endtask : value
    function automatic logic [7:0] wave(int c, int s, logic x);
        logic [3:0] o;
        logic [3:0] e;
        case (c)
            0: begin o = {3'h0, x}; e = 4'hE; end
            1: begin o = {x, 3'h1}; e = 4'h0; end
            2: begin o = {2'h0, ~x, x}; e = 4'hC; end
            default: begin o = {2'h1, x, 1'b0}; e = 4'h0; end
        endcase
        o = o ^ {s[0], s[1], s[0], s[1]};
        return {e, o & ~e};
    endfunction : wave
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    initial begin
        repeat (30000) @(posedge sys_clk);
        miscompares++;
        results;
    end
    initial begin
        rq = '0;
        tcnt = 16'h0000;
        tick = 1'b0;
        src = 2'h0;
        pw = 2'h0;
        nadc = 0;
        reset = 1'b1;
        seed = $urandom(13);
        w(16);
        reset <= 1'b0;
        w(2);
        for (k = 0; k < 2; k++) begin
            rd(k * 16, d);
            chk(d, 32'h0);
            wr(k * 16, 32'hFF);
            chk(br, 2'h0);
            rd(k * 16, d);
            chk(d, k ? 32'h3F : 32'hFF);
        end
        rd(8'h20, d);
        chk(d, 32'h0);
        wr(8'h20, 1);
        chk(br, 2'h2);
        // every edge kind on both units, then an overwrite
        for (k = 0; k < 8; k++) begin
            u = k / 4;
            m = 4 + k % 4;
            n = (m == 6) ? 4 : (m == 7) ? 16 : 1;
            wr(u * 16, 0);
            wr(u * 16, m);
            wr(u * 16 + 12, 1);
            v = 16'($urandom);
            tcnt <= v;
            pulse(u, n - 1);
            chk(flg[u], 1'b0);
            pulse(u, 1);
            chk(flg[u], 1'b1);
            value(u * 16, v);
            tcnt <= ~v;
            pulse(u, n);
            value(u * 16, ~v);
            wr(u * 16 + 12, 1);
            chk(flg[u], 1'b0);
        end
        wr(0, 7);
        pulse(0, 3);
        wr(0, 6);
        wr(12, 1);
        pulse(0, 1);
        chk(flg[0], 1'b1);
        wr(0, 0);
        wr(0, 6);
        wr(12, 1);
        pulse(0, 1);
        chk(flg[0], 1'b0);
        // compare actions, then reserved codes on the plain unit
        v = 16'($urandom_range(256, 65000));
        lat = 1'b0;
        for (k = 0; k < 11; k++) begin
            u = (k > 6) ? 1 : 0;
            m = mt[k];
            if (k == 0 || k == 7) begin
                wr(u * 16 + 4, v[7:0]);
                wr(u * 16 + 8, v[15:8]);
                value(u * 16, v);
            end
            tcnt <= v - 16'h0001;
            wr(u * 16, m);
            wr(u * 16 + 12, 1);
            tcnt <= v;
            w(6);
            chk(flg[u], m >= 8 || (m == 2 && u == 0));
            if (m == 0) lat = 1'b0;
            if (m == 8) lat = 1'b1;
            if (m == 9) lat = 1'b0;
            if (m == 2 && u == 0) lat = ~lat;
            if (u == 0 && m != 0 && m < 10)
                chk({eoe_n, eo[0]}, {4'hE, lat});
            else if (u == 0) chk(eoe_n, 4'hF);
            if (u == 1 && m == 8) chk({poe_n, po}, 2'h1);
            if (m == 11) begin
                chk(nadc, 1);
                chk(tcnt, 16'h0000);
            end
        end
        // every output layout and polarity on the enhanced unit
        for (k = 0; k < 16; k++) begin
            pw <= 2'($urandom);
            wr(0, (k / 4) * 64 + ($urandom % 4) * 16 + 12 + k % 4);
            w(3);
            chk({eoe_n, eo & ~eoe_n}, wave(k / 4, k % 4, pw[0]));
        end
        results;
    end
endmodule : capture_compare_unit_tb
`default_nettype wire
